// ==== hdl/reset_and_interrupt_control.v ====
// Reset generation and interrupt request logic for an 8-bit core
// Assumes one fast clock, an APB master, and on-chip request sources
// How it works
// - Four reset sources; malfunction resets last 23 clocks
// - Malfunction reset may fire at power-up
// - Reset clears global enable, enables, latches
// - Reset clears prescaler; watchdog stays enabled
// - Reset pin low twelve clocks applies reset
// - Pin high releases reset; fetch from FFFE
// - Fetch from SPECIAL_FUNCTION_AREA, DATA_BUFFER_REGION, RAM-if-selected traps
// - Trap action bit picks reset or interrupt
// - Watchdog action bit picks reset or interrupt
// - Illegal oscillator disable gives system clock reset
// - Twenty-four sources, four non-maskable
// - Requests set latches held until serviced
// - Maskable needs global and own enable
// - Fixed priority; soft trap and bad opcode share the top level
// - Fixed vectors for reset and non-maskables
// - Maskable vectors computed from latch number
// - Converter request kept on accept; sets win over clears
// - Accepted source latch cleared immediately
// - Accept stacks global enable then clears it
// - Acceptance takes eight machine cycles
// - Writing zero clears latch; one ignored
`timescale 1ns/100ps
`include "reset_irq_map.vh"

module reset_and_interrupt_control #(
   parameter MAL_CYC = `MAL_RST_FC
) (
   // Clock and power reset
   input  wire        clk_in,
   input  wire        rst_n_in,
   // APB slave
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output reg         pready_out,
   output reg         pslverr_out,
   // Reset pin and malfunction detectors
   input  wire        reset_pin_n_in,
   input  wire        fetch_valid_in,
   input  wire [15:0] fetch_addr_in,
   input  wire        wdog_event_in,
   // Request sources
   input  wire        soft_trap_irq_in,
   input  wire        bad_opcode_irq_in,
   input  wire [23:4] req_in,
   // CPU handshake
   input  wire        instr_done_in,
   input  wire        reti_in,
   input  wire        stacked_ie_in,
   // Outputs to core
   output reg         core_rst_n_out,
   output reg  [15:0] vector_out,
   output reg         accept_busy_out,
   output reg         accept_done_out,
   output reg         stacked_ie_out,
   output reg         mcycle_en_out,
   output reg         wdog_enable_out
);

   reg        rst_meta;
   reg        rst_sync;
   reg        pin_meta;
   reg        pin_sync;
   reg [3:0]  low_cnt;
   reg        ext_active;
   reg [7:0]  mal_cnt;
   reg        core_rst;
   reg        global_irq_enable;
   reg        ext0_pin_enable;
   reg        trap_ram_select;
   reg        trap_action_select;
   reg        wdog_action_select;
   reg [23:4] source_enable_flags;
   reg [23:2] request_latches;
   reg [7:0]  system_ctrl2;
   reg [7:0]  prescaler;
   reg [5:0]  busy_cnt;
   reg [2:0]  cause;
   reg [23:2] next_latches;
   reg        pick_valid;
   reg        pick_soft;
   reg [4:0]  pick_idx;
   reg        sysclk_fault;
   integer    i;

   localparam integer ACC_LAST = `ACCEPT_CYC - 1;

   wire apb_wr = psel_in & penable_in & pready_out & pwrite_in;
   wire addr_ok = (paddr_in == `OFF_CTRL) | (paddr_in == `OFF_ENABLE) | (paddr_in == `OFF_LATCH) |
                  (paddr_in == `OFF_SYSCTRL2) | (paddr_in == `OFF_STATUS);

   function in_range;
      input [15:0] a;
      input [15:0] lo;
      input [15:0] hi;
      begin
         in_range = (a >= lo) && (a <= hi);
      end
   endfunction

   function [15:0] vec_of;
      input [4:0] n;
      begin
         if (n == `LATCH_TRAP)
            vec_of = `VEC_TRAP;
         else if (n == `LATCH_WDOG)
            vec_of = `VEC_WDOG;
         else if (n < 5'd16)
            vec_of = `VEC_LOW_BASE - {10'h000, n - 5'd4, 1'b0};
         else
            vec_of = `VEC_HIGH_BASE - {10'h000, n - 5'd16, 1'b0};
      end
   endfunction

   // Fetch into a trapped region
   wire trap_hit = fetch_valid_in & (in_range(fetch_addr_in, `SFR_LO, `SFR_HI) |
                   in_range(fetch_addr_in, `DBR_LO, `DBR_HI) |
                   (trap_ram_select & in_range(fetch_addr_in, `RAM_LO, `RAM_HI)));
   wire trap_rst = trap_hit & trap_action_select;
   wire wdog_rst = wdog_event_in & wdog_action_select;

   // Oscillator disable check on a write to system control 2
   always @* begin
      sysclk_fault = 1'b0;
      if (apb_wr && paddr_in == `OFF_SYSCTRL2) begin
         if (system_ctrl2[`SC2_FAST_EN] & system_ctrl2[`SC2_SLOW_EN] &
             ~pwdata_in[`SC2_FAST_EN] & ~pwdata_in[`SC2_SLOW_EN])
            sysclk_fault = 1'b1;
         if (system_ctrl2[`SC2_FAST_EN] & ~pwdata_in[`SC2_FAST_EN] & ~pwdata_in[`SC2_CLK_SEL])
            sysclk_fault = 1'b1;
         if (system_ctrl2[`SC2_SLOW_EN] & ~pwdata_in[`SC2_SLOW_EN] & pwdata_in[`SC2_CLK_SEL])
            sysclk_fault = 1'b1;
      end
   end

   // Power reset release; every other flop resets from this copy
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // Reset pin filter and malfunction timer
   always @(posedge clk_in or negedge rst_sync) begin
      if (!rst_sync) begin
         pin_meta   <= 1'b1;
         pin_sync   <= 1'b1;
         low_cnt    <= 4'h0;
         ext_active <= 1'b0;
         mal_cnt    <= MAL_CYC[7:0];
         core_rst   <= 1'b1;
      end else begin
         pin_meta <= reset_pin_n_in;
         pin_sync <= pin_meta;
         if (pin_sync) begin
            low_cnt    <= 4'h0;
            ext_active <= 1'b0;
         end else if (low_cnt == `EXT_MIN_CYC - 1) begin
            ext_active <= 1'b1;
         end else begin
            low_cnt <= low_cnt + 4'h1;
         end
         if (!core_rst && (trap_rst | wdog_rst | sysclk_fault))
            mal_cnt <= MAL_CYC[7:0];
         else if (mal_cnt != 8'h00)
            mal_cnt <= mal_cnt - 8'h01;
         core_rst <= ~rst_sync | ext_active | (mal_cnt > 8'h01);
      end
   end

   // Priority pick: non-maskables first, then lowest latch number
   always @* begin
      pick_valid = 1'b0;
      pick_soft  = 1'b0;
      pick_idx   = 5'd0;
      for (i = `LATCH_LAST; i >= `LATCH_EXT0; i = i - 1)
         if (request_latches[i] & source_enable_flags[i] & global_irq_enable &
             (i != `LATCH_EXT0 || ext0_pin_enable)) begin
            pick_valid = 1'b1;
            pick_idx   = i[4:0];
         end
      if (request_latches[`LATCH_WDOG]) begin
         pick_valid = 1'b1;
         pick_idx   = `LATCH_WDOG;
      end
      if (request_latches[`LATCH_TRAP]) begin
         pick_valid = 1'b1;
         pick_idx   = `LATCH_TRAP;
      end
      if (soft_trap_irq_in | bad_opcode_irq_in) begin
         pick_valid = 1'b1;
         pick_soft  = 1'b1;
      end
   end

   wire accept = instr_done_in & pick_valid & ~accept_busy_out & ~core_rst;

   // Latch update: software clear, accept clear, then sets win
   always @* begin
      next_latches = request_latches;
      if (apb_wr && paddr_in == `OFF_LATCH)
         next_latches = next_latches & pwdata_in[23:2];
      // Only the chosen latch clears; a converter request is not dropped
      if (accept && !pick_soft)
         next_latches[pick_idx] = 1'b0;
      next_latches[23:4] = next_latches[23:4] | req_in;
      next_latches[`LATCH_TRAP] = next_latches[`LATCH_TRAP] | (trap_hit & ~trap_action_select);
      next_latches[`LATCH_WDOG] = next_latches[`LATCH_WDOG] | (wdog_event_in & ~wdog_action_select);
   end

   // Registers, acceptance sequence and prescaler
   always @(posedge clk_in or negedge rst_sync) begin
      if (!rst_sync) begin
         global_irq_enable   <= 1'b0;
         ext0_pin_enable     <= 1'b0;
         trap_ram_select     <= 1'b0;
         trap_action_select  <= 1'b1;
         wdog_action_select  <= 1'b1;
         wdog_enable_out     <= 1'b1;
         source_enable_flags <= 20'h00000;
         request_latches     <= 22'h000000;
         system_ctrl2        <= `SC2_RESET;
         prescaler           <= 8'h00;
         busy_cnt            <= 6'h00;
         cause               <= 3'h0;
         core_rst_n_out      <= 1'b0;
         vector_out          <= `VEC_RESET;
         accept_busy_out     <= 1'b0;
         accept_done_out     <= 1'b0;
         stacked_ie_out      <= 1'b0;
         mcycle_en_out       <= 1'b0;
         prdata_out          <= 32'h0000_0000;
         pready_out          <= 1'b0;
         pslverr_out         <= 1'b0;
      end else begin
         core_rst_n_out  <= ~core_rst;
         accept_done_out <= 1'b0;
         pready_out      <= psel_in & ~penable_in;
         pslverr_out     <= psel_in & ~penable_in & ~addr_ok;
         if (psel_in && !penable_in) begin
            case (paddr_in)
               `OFF_CTRL:     prdata_out <= {26'h0, wdog_enable_out, wdog_action_select, trap_action_select,
                                             trap_ram_select, ext0_pin_enable, global_irq_enable};
               `OFF_ENABLE:   prdata_out <= {8'h00, source_enable_flags, 4'h0};
               `OFF_LATCH:    prdata_out <= {8'h00, request_latches, 2'b00};
               `OFF_SYSCTRL2: prdata_out <= {24'h0, system_ctrl2};
               `OFF_STATUS:   prdata_out <= {12'h000, cause, accept_busy_out, vector_out};
               default:       prdata_out <= 32'h0000_0000;
            endcase
         end
         if (trap_rst)
            cause <= 3'h1;
         else if (wdog_rst)
            cause <= 3'h2;
         else if (sysclk_fault)
            cause <= 3'h4;
         if (core_rst) begin
            global_irq_enable   <= 1'b0;
            source_enable_flags <= 20'h00000;
            request_latches     <= 22'h000000;
            ext0_pin_enable     <= 1'b0;
            trap_ram_select     <= 1'b0;
            trap_action_select  <= 1'b1;
            wdog_action_select  <= 1'b1;
            wdog_enable_out     <= 1'b1;
            system_ctrl2        <= `SC2_RESET;
            prescaler           <= 8'h00;
            mcycle_en_out       <= 1'b0;
            busy_cnt            <= 6'h00;
            accept_busy_out     <= 1'b0;
            vector_out          <= `VEC_RESET;
         end else begin
            prescaler     <= prescaler + 8'h01;
            mcycle_en_out <= (prescaler[1:0] == 2'b11);
            request_latches <= next_latches;
            if (apb_wr) begin
               case (paddr_in)
                  `OFF_CTRL: begin
                     global_irq_enable  <= pwdata_in[`CTRL_IE];
                     ext0_pin_enable    <= pwdata_in[`CTRL_EXT0];
                     trap_ram_select    <= pwdata_in[`CTRL_RAMSEL];
                     trap_action_select <= pwdata_in[`CTRL_TRAPACT];
                     wdog_action_select <= pwdata_in[`CTRL_WDACT];
                     wdog_enable_out    <= pwdata_in[`CTRL_WDEN];
                  end
                  `OFF_ENABLE:   source_enable_flags <= pwdata_in[23:4];
                  `OFF_SYSCTRL2: system_ctrl2 <= pwdata_in[7:0] & 8'hE0;
                  default: ;
               endcase
            end
            if (reti_in && !accept_busy_out)
               global_irq_enable <= stacked_ie_in;
            if (accept) begin
               stacked_ie_out    <= global_irq_enable;
               global_irq_enable <= 1'b0;
               vector_out        <= pick_soft ? `VEC_SOFT : vec_of(pick_idx);
               accept_busy_out   <= 1'b1;
               busy_cnt          <= ACC_LAST[5:0];
            end else if (accept_busy_out) begin
               if (busy_cnt == 6'h00) begin
                  accept_busy_out <= 1'b0;
                  accept_done_out <= 1'b1;
               end else begin
                  busy_cnt <= busy_cnt - 6'h01;
               end
            end
         end
      end
   end

endmodule

// ==== shared/reset_irq_map.vh ====
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the reset and interrupt controller only
`ifndef RESET_IRQ_MAP_VH
`define RESET_IRQ_MAP_VH

// APB byte offsets
`define OFF_CTRL      8'h00
`define OFF_ENABLE    8'h04
`define OFF_LATCH     8'h08
`define OFF_SYSCTRL2  8'h0C
`define OFF_STATUS    8'h10

// Control register fields
`define CTRL_IE       0
`define CTRL_EXT0     1
`define CTRL_RAMSEL   2
`define CTRL_TRAPACT  3
`define CTRL_WDACT    4
`define CTRL_WDEN     5
`define CTRL_RESET    32'h0000_0038

// System control 2 fields
`define SC2_FAST_EN   7
`define SC2_SLOW_EN   6
`define SC2_CLK_SEL   5
`define SC2_RESET     8'h80

// Latch and source numbering
`define LATCH_TRAP    2
`define LATCH_WDOG    3
`define LATCH_EXT0    4
`define LATCH_FIRST   2
`define LATCH_LAST    23

// Vectors
`define VEC_RESET     16'hFFFE
`define VEC_SOFT      16'hFFFC
`define VEC_TRAP      16'hFFFA
`define VEC_WDOG      16'hFFF8
`define VEC_LOW_BASE  16'hFFF6
`define VEC_HIGH_BASE 16'hFFBE

// Trapped fetch regions (inclusive)
`define SFR_LO        16'h0000
`define SFR_HI        16'h003F
`define RAM_LO        16'h0040
`define RAM_HI        16'h083F
`define DBR_LO        16'h0F80
`define DBR_HI        16'h0FFF

// Timing: fast clock 100 MHz, one machine cycle is four clocks
`define CLK_PER_MCYC  4
`define MAL_RST_FC    24
`define EXT_MIN_MCYC  3
`define EXT_MIN_CYC   (`EXT_MIN_MCYC * `CLK_PER_MCYC)
`define ACCEPT_MCYC   8
`define ACCEPT_CYC    (`ACCEPT_MCYC * `CLK_PER_MCYC)

`endif

// ==== sim/core_model.sv ====
// CPU core stand-in: offers accept slots, returns after each service
// Assumes the controller's accept handshake on the same clock
`timescale 1ns/100ps
module core_model #(
   parameter logic [2:0] GAP = 3'h4
) (
   input  wire logic clk_in,
   input  wire logic accept_busy_out,
   input  wire logic accept_done_out,
   input  wire logic stacked_ie_out,
   output logic      instr_done_in = 1'h0,
   output logic      reti_in = 1'h0,
   output logic      stacked_ie_in = 1'h0
);
   logic [2:0] gap = 3'h0;
   always @(posedge clk_in) begin
      if (accept_done_out) gap <= GAP;
      else if (gap != 3'h0) gap <= gap - 3'h1;
      reti_in <= (gap == 3'h1);
      stacked_ie_in <= stacked_ie_out;
      instr_done_in <= !accept_busy_out && gap == 3'h0;
   end
endmodule

// ==== sim/ric_asserts.sv ====
// Port checker for the reset and interrupt controller
// Assumes binding into reset_and_interrupt_control with its MAL_CYC
`timescale 1ns/100ps
module ric_asserts #(
   parameter int MAL_CYC = 24
) (
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic        reset_pin_n_in,
   input wire logic        core_rst_n_out,
   input wire logic [15:0] vector_out,
   input wire logic        accept_busy_out,
   input wire logic        accept_done_out,
   input wire logic        mcycle_en_out,
   input wire logic        wdog_enable_out
);
   localparam int MAL_HI = MAL_CYC + 8;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence pin_low12;
      !reset_pin_n_in [*6] ##1 !reset_pin_n_in [*6];
   endsequence
   sequence acc_start;
      $rose(accept_busy_out);
   endsequence
   a_acc_length: assert property (acc_start |-> ##[31:32] accept_done_out)
      else $error("accept length wrong");
   a_done_pulse: assert property (accept_done_out |=> !accept_done_out && !accept_busy_out)
      else $error("done not a pulse");
   a_rst_vector: assert property (!core_rst_n_out |-> vector_out == 16'hFFFE)
      else $error("reset vector wrong");
   a_pin_reset: assert property (pin_low12 |-> ##[0:6] !core_rst_n_out)
      else $error("pin reset missed");
   a_pin_release: assert property ($rose(reset_pin_n_in) |-> ##[1:MAL_HI] core_rst_n_out)
      else $error("pin release late");
   a_mal_bound: assert property ($fell(core_rst_n_out) && reset_pin_n_in && $past(reset_pin_n_in)
      |-> ##[1:MAL_HI] core_rst_n_out)
      else $error("malfunction reset too long");
   a_wdog_rst: assert property (!core_rst_n_out && !$past(core_rst_n_out) |-> wdog_enable_out)
      else $error("watchdog not enabled");
   a_vec_table: assert property (acc_start |-> !vector_out[0] && vector_out != 16'hFFFE
      && (vector_out >= 16'hFFE0 || (vector_out <= 16'hFFBE && vector_out >= 16'hFFB0)))
      else $error("vector out of table");
   a_mcycle_gap: assert property (mcycle_en_out |=> !mcycle_en_out [*3])
      else $error("machine cycle pulse too close");
endmodule
bind reset_and_interrupt_control ric_asserts #(.MAL_CYC(MAL_CYC)) ric_asserts_i (.clk_in, .rst_n_in,
   .reset_pin_n_in, .core_rst_n_out, .vector_out, .accept_busy_out, .accept_done_out, .mcycle_en_out,
   .wdog_enable_out);

// ==== sim/tb_top.sv ====
// Self-checking bench for the reset and interrupt controller
// Assumes APB access, core_model as the core, checker bound in
`timescale 1ns/100ps
module tb_top;
   logic        clk_in = 1'h0, rst_n_in = 1'h0, psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out, q;
   logic        pready_out, pslverr_out, e, seen, busy_seen;
   logic        reset_pin_n_in = 1'h1, fetch_valid_in = 1'h0, wdog_event_in = 1'h0;
   logic [15:0] fetch_addr_in = 16'h0, vector_out;
   logic        soft_trap_irq_in = 1'h0, bad_opcode_irq_in = 1'h0, instr_done_in, reti_in, stacked_ie_in;
   logic [23:4] req_in = 20'h0;
   logic        core_rst_n_out, accept_busy_out, accept_done_out, stacked_ie_out, wdog_enable_out, mcycle_en_out;
   logic [31:0] tt [8] = '{32'h0138003F, 32'h00380040, 32'h00380F7F, 32'h01380F80,
                           32'h01380FFF, 32'h013C083F, 32'h003C0840, 32'h00380100};
   logic [31:0] sc [5] = '{32'h01C000, 32'h01C040, 32'h01E0A0, 32'h00C080, 32'h00E060};
   int          failures = 0, comparisons = 0, cyc = 0, n, k, mc;
   reset_and_interrupt_control #(.MAL_CYC(8)) reset_and_interrupt_control_i (.clk_in, .rst_n_in,
      .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
      .reset_pin_n_in, .fetch_valid_in, .fetch_addr_in, .wdog_event_in, .soft_trap_irq_in,
      .bad_opcode_irq_in, .req_in, .instr_done_in, .reti_in, .stacked_ie_in, .core_rst_n_out,
      .vector_out, .accept_busy_out, .accept_done_out, .stacked_ie_out, .mcycle_en_out,
      .wdog_enable_out);
   core_model core_model_i (.clk_in, .accept_busy_out, .accept_done_out, .stacked_ie_out,
      .instr_done_in, .reti_in, .stacked_ie_in);
   always #5 clk_in = ~clk_in;
   always @(negedge clk_in) if (core_rst_n_out === 1'h0) seen = 1'h1;
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         test_done;
      end
   end
   task test_done;
      if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in) penable_in <= 1'h1;
      // Answer taken at the edge that samples pready high
      do @(posedge clk_in); while (pready_out !== 1'h1);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(q, exp);
   endtask
   task pulse(input logic [23:0] r);
      @(posedge clk_in) req_in <= r[23:4];
      @(posedge clk_in) req_in <= 20'h0;
   endtask
   task ev(input logic [15:0] a, input logic w);
      @(posedge clk_in);
      fetch_valid_in <= !w;
      fetch_addr_in <= a;
      wdog_event_in <= w;
      @(posedge clk_in);
      fetch_valid_in <= 1'h0;
      wdog_event_in <= 1'h0;
   endtask
   task wait_up;
      n = 0;
      do begin @(negedge clk_in); n++; end while (core_rst_n_out !== 1'h1 && n < 300);
      chk(core_rst_n_out, 1'h1);
   endtask
   task rst_check(input logic exp);
      repeat (12) @(negedge clk_in);
      chk(seen, exp);
      wait_up;
   endtask
   task noacc;
      busy_seen = 1'h0;
      mc = 0;
      repeat (40) @(negedge clk_in) begin
         if (accept_busy_out !== 1'h0) busy_seen = 1'h1;
         if (mcycle_en_out === 1'h1) mc++;
      end
      chk(busy_seen, 1'h0);
      chk(mc, 10);
   endtask
   // Let a pending return restore the global enable
   task settle;
      repeat (8) @(posedge clk_in);
   endtask
   task acc(input logic [15:0] v, input logic stk, input logic [31:0] ctrl, input logic [31:0] lat);
      n = 0;
      do begin @(negedge clk_in); n++; end while (accept_busy_out !== 1'h1 && n < 60);
      chk(vector_out, v);
      chk(stacked_ie_out, stk);
      rd(8'h00, ctrl & 32'hFFFFFFFE);
      rd(8'h08, lat);
      n = 0;
      do begin @(negedge clk_in); n++; end while (accept_done_out !== 1'h1 && n < 60);
      chk(accept_done_out, 1'h1);
   endtask
   initial begin
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'h1;
      wait_up;
      rd(8'h00, 32'h38);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'h80);
      rd(8'h14, 32'h0);
      chk(e, 1'h1);
      apb(1'h1, 8'h04, 32'h20);
      pulse(24'h20);
      rd(8'h08, 32'h20);
      noacc;
      apb(1'h1, 8'h08, 32'hFFFFFFFF);
      rd(8'h08, 32'h20);
      apb(1'h1, 8'h08, 32'hFFFFFFDF);
      rd(8'h08, 32'h0);
      // External input 0 waits for its pin enable
      apb(1'h1, 8'h04, 32'h10);
      apb(1'h1, 8'h00, 32'h39);
      pulse(24'h10);
      noacc;
      apb(1'h1, 8'h08, 32'h0);
      for (k = 4; k < 24; k++) begin
         apb(1'h1, 8'h04, 32'h1 << k);
         apb(1'h1, 8'h00, 32'h3B);
         pulse(24'h1 << k);
         acc(k < 16 ? 16'hFFF6 - 16'(2 * (k - 4)) : 16'hFFBE - 16'(2 * (k - 16)), 1'h1, 32'h3B, 32'h0);
      end
      settle;
      apb(1'h1, 8'h00, 32'h3A);
      apb(1'h1, 8'h04, 32'h10200);
      pulse(24'h10200);
      apb(1'h1, 8'h00, 32'h3B);
      acc(16'hFFEC, 1'h1, 32'h3B, 32'h10000);
      acc(16'hFFBE, 1'h1, 32'h3B, 32'h0);
      // Non-maskable sources with global enable off
      settle;
      apb(1'h1, 8'h00, 32'h30);
      for (k = 0; k < 2; k++) begin
         @(posedge clk_in) {soft_trap_irq_in, bad_opcode_irq_in} <= 2'h2 >> k;
         acc(16'hFFFC, 1'h0, 32'h30, 32'h0);
         @(posedge clk_in) {soft_trap_irq_in, bad_opcode_irq_in} <= 2'h0;
      end
      ev(16'h0010, 1'h0);
      acc(16'hFFFA, 1'h0, 32'h30, 32'h0);
      apb(1'h1, 8'h00, 32'h28);
      ev(16'h0000, 1'h1);
      acc(16'hFFF8, 1'h0, 32'h28, 32'h0);
      apb(1'h1, 8'h00, 32'h18);
      apb(1'h1, 8'h04, 32'hFF0);
      seen = 1'h0;
      ev(16'h0000, 1'h1);
      rst_check(1'h1);
      chk(wdog_enable_out, 1'h1);
      rd(8'h04, 32'h0);
      rd(8'h00, 32'h38);
      for (k = 0; k < 8; k++) begin
         apb(1'h1, 8'h00, {24'h0, tt[k][23:16]});
         seen = 1'h0;
         ev(tt[k][15:0], 1'h0);
         rst_check(tt[k][24]);
      end
      for (k = 0; k < 5; k++) begin
         apb(1'h1, 8'h0C, {24'h0, sc[k][15:8]});
         seen = 1'h0;
         apb(1'h1, 8'h0C, {24'h0, sc[k][7:0]});
         rst_check(sc[k][16]);
      end
      for (k = 0; k < 2; k++) begin
         seen = 1'h0;
         @(posedge clk_in) reset_pin_n_in <= 1'h0;
         repeat (k ? 16 : 6) @(posedge clk_in);
         reset_pin_n_in <= 1'h1;
         rst_check(k[0]);
      end
      test_done;
   end
endmodule
